// >>> inc/lfrtc_defs.vh
// constants for the low-frequency real-time counter
`ifndef LFRTC_DEFS_VH
`define LFRTC_DEFS_VH
// register byte offsets (low 12 bits of the address)
`define LFRTC_TASK_START 12'h000
`define LFRTC_TASK_STOP 12'h004
`define LFRTC_TASK_CLEAR 12'h008
`define LFRTC_TASK_NEAR_WRAP 12'h00C
`define LFRTC_EVT_TICK 12'h100
`define LFRTC_EVT_WRAP 12'h104
`define LFRTC_EVT_MATCH0 12'h140
`define LFRTC_ROUTE_EN 12'h340
`define LFRTC_ROUTE_SET 12'h344
`define LFRTC_ROUTE_CLR 12'h348
`define LFRTC_COUNT 12'h504
`define LFRTC_RATE_DIV 12'h508
`define LFRTC_MATCH_VAL0 12'h540
// widths and counts
`define LFRTC_CNT_W 24
`define LFRTC_DIV_W 12
`define LFRTC_NUM_MATCH 4
`define LFRTC_NUM_EVT 6
// event indices: tick, wrap, then matches
`define LFRTC_EV_TICK 0
`define LFRTC_EV_WRAP 1
`define LFRTC_EV_MATCH 2
// route enable field positions in the register
`define LFRTC_RT_TICK_BIT 0
`define LFRTC_RT_WRAP_BIT 1
`define LFRTC_RT_MATCH_BIT 16
// values
`define LFRTC_NEAR_WRAP_VAL 24'hFFFFF0
`define LFRTC_ALL_ONES 24'hFFFFFF
`define LFRTC_DIV_RESET 12'h000
`define LFRTC_ROUTE_RESET 6'h00
// wait cycles inserted on a counter read
`define LFRTC_READ_STALL 2'h3
`endif

// >>> rtl/lfrtc_top.v
// low-frequency real-time counter with an ahb-lite register slave
//
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "lfrtc_defs.vh"

// Summary of operation
// [R1] 24-bit up-counter on the slow clock with tick, match, wrap events
// [R2] counter runs from the slow clock alone, no fast clock request needed; here the counter is clocked by i_mclk sampling the slow clock
// [R3] advance when divider is zero, then divider reloads the rate setting
// [R4] rate divider setting is 12 bits, divisor one to 4096
// [R5] rate setting writable only while stopped; writes ignored when running
// [R6] start, clear, near-wrap reload the divider from the rate setting
// [R7] tick event on every advance, individually routable
// [R8] near-wrap task loads the counter with 0xFFFFF0
// [R9] wrap event when counter rolls from all ones to zero
// [R10] wrap and tick routing disabled after reset
// [R11] each event has its own route enable; disabled events request no clock
// [R12] four match registers, each driving its own match event
// [R13] clear with a zero match value gives no match event
// [R14] start while counter equals match value gives no match event
// [R15] match when counter steps from value minus one to value
// [R16] match value two above count always fires when reached
// [R17] match value equal or one above count may not fire
// [R18] old match value one or two ahead may fire; further ahead never
// [R19] processor sees a fast-domain copy captured on read
// [R20] clear, stop, near-wrap act after one slow falling then rising edge
// [R21] start runs the counter on from its held value
// [R22] a slow falling edge must follow start before the first advance
// [R23] counter read holds ready low three cycles, five cycles in all
// [R24] clear zeroes the counter; stop halts and keeps the value
module lfrtc_top
(
   input wire i_mclk,
   input wire i_rst,
   input wire i_low_freq_clock,
   input wire i_hsel,
   input wire [31:0] i_haddr,
   input wire [1:0] i_htrans,
   input wire i_hwrite,
   input wire [2:0] i_hsize,
   input wire [31:0] i_hwdata,
   input wire i_hready,
   output reg [31:0] o_hrdata,
   output reg o_hreadyout,
   output reg o_hresp,
   output reg [5:0] o_event,
   output reg o_clk_request,
   output reg o_running
);

   // the slow clock is sampled as plain data on the fast clock, so all
   // counter state lives in one domain and nothing else has to cross
   // between clocks beyond the input synchroniser
   // hazard: every slow edge is seen about three fast cycles late; this
   // only adds to the task and increment jitter software already allows
   // tasks that wait for a slow edge are queued in pending flags, so a
   // burst of task writes inside one slow period is merged into one wait
   // the read copy of the count is taken on the fast clock at the address
   // edge; the counter itself never changes between slow edges, so the
   // copy is always a settled value and the stall only keeps the bus
   // timing fixed for software

   // slow clock synchroniser and edge history
   reg lf_s1_reg;
   reg lf_s2_reg;
   reg lf_s3_reg;
   // counter core
   reg run_reg;
   reg armed_reg;
   reg [23:0] cnt_reg;
   reg [11:0] div_reg;
   reg [11:0] rate_reg;
   reg [5:0] route_reg;
   wire [5:0] evt_reg;
   reg pend_clear_reg;
   reg pend_stop_reg;
   reg pend_wrap_reg;
   reg fall_seen_reg;
   reg [23:0] match_reg [0:3];
   // bus data phase
   reg dp_wr_reg;
   reg [11:0] dp_addr_reg;
   reg [1:0] stall_reg;

   wire lf_rise;
   wire lf_fall;
   wire task_now;
   wire advance;
   wire [23:0] cnt_inc;
   wire [5:0] ev_now;
   wire a_sel;
   wire wr_start;
   wire wr_stop;
   wire wr_clear;
   wire wr_wrap;
   wire any_pend;
   reg [31:0] rd_mux;

   // edges of the synchronised slow clock
   // only the second and third stages are read, never the first, so a
   // metastable first stage cannot make a false edge
   assign lf_rise = lf_s2_reg & ~lf_s3_reg;
   assign lf_fall = ~lf_s2_reg & lf_s3_reg;
   assign any_pend = pend_clear_reg | pend_stop_reg | pend_wrap_reg;
   // [R20] fall then rise
   assign task_now = lf_rise & fall_seen_reg & any_pend;
   // [R3] advance on zero
   assign advance = run_reg & armed_reg & lf_rise & ~task_now &
      (div_reg == `LFRTC_DIV_RESET);
   assign cnt_inc = cnt_reg + 24'h000001;
   // [R7] tick on advance
   assign ev_now[`LFRTC_EV_TICK] = advance;
   // [R9] roll from all ones
   assign ev_now[`LFRTC_EV_WRAP] = advance & (cnt_reg == `LFRTC_ALL_ONES);

   // data-phase write strobes for the task registers
   assign wr_start = dp_wr_reg & (dp_addr_reg == `LFRTC_TASK_START) &
      i_hwdata[0];
   assign wr_stop = dp_wr_reg & (dp_addr_reg == `LFRTC_TASK_STOP) &
      i_hwdata[0];
   assign wr_clear = dp_wr_reg & (dp_addr_reg == `LFRTC_TASK_CLEAR) &
      i_hwdata[0];
   assign wr_wrap = dp_wr_reg & (dp_addr_reg == `LFRTC_TASK_NEAR_WRAP) &
      i_hwdata[0];
   assign a_sel = i_hsel & i_htrans[1] & i_hready;

   // match registers and their events, one per entry
   genvar gi;
   generate
      for (gi = 0; gi < `LFRTC_NUM_MATCH; gi = gi + 1)
      begin : g_match
         // [R15] match only on a real step onto the value
         // [R16] a new value is compared from the next advance on
         // [R17] a value equal to the count waits for a full wrap
         // [R18] an old value is replaced at once, never fires later
         // loads from clear or near-wrap never advance, so never match
         assign ev_now[`LFRTC_EV_MATCH + gi] = advance &
            (cnt_inc == match_reg[gi]);
         // [R12] software-written match value
         always @(posedge i_mclk or posedge i_rst)
         begin
            if (i_rst)
               match_reg[gi] <= 24'h000000;
            else if (dp_wr_reg &&
               dp_addr_reg == `LFRTC_MATCH_VAL0 + 12'h004 * gi)
               match_reg[gi] <= i_hwdata[23:0];
         end
      end
   endgenerate

   // sticky event flags, one per event; a new event wins over a write
   genvar fi;
   generate
      for (fi = 0; fi < `LFRTC_NUM_EVT; fi = fi + 1)
      begin : g_flag
         // tick and wrap flags first, then the match flags from their base
         localparam [11:0] FLAG_ADDR = (fi < `LFRTC_EV_MATCH) ?
            `LFRTC_EVT_TICK + 4 * fi :
            `LFRTC_EVT_MATCH0 + 4 * (fi - `LFRTC_EV_MATCH);
         reg flag_reg;
         assign evt_reg[fi] = flag_reg;
         // flags set whether routed or not; software writes bit 0
         always @(posedge i_mclk or posedge i_rst)
         begin
            if (i_rst)
               flag_reg <= 1'b0;
            else if (ev_now[fi])
               flag_reg <= 1'b1;
            else if (dp_wr_reg && dp_addr_reg == FLAG_ADDR)
               flag_reg <= i_hwdata[0];
         end
      end
   endgenerate

   // two-flop synchroniser plus one stage for edge detection
   always @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         lf_s1_reg <= 1'b0;
         lf_s2_reg <= 1'b0;
         lf_s3_reg <= 1'b0;
      end
      else
      begin
         lf_s1_reg <= i_low_freq_clock;
         lf_s2_reg <= lf_s1_reg;
         lf_s3_reg <= lf_s2_reg;
      end
   end

   // counter, divider and task sequencing
   // [R2] counting runs on i_mclk sampling the slow clock, no clock request
   // a pending task on the same slow rising edge as an advance wins and
   // suppresses that advance, so a load is never followed by a step
   always @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         run_reg <= 1'b0;
         armed_reg <= 1'b0;
         cnt_reg <= 24'h000000;
         div_reg <= `LFRTC_DIV_RESET;
         rate_reg <= `LFRTC_DIV_RESET;
         // [R10] routing off at reset
         route_reg <= `LFRTC_ROUTE_RESET;
         pend_clear_reg <= 1'b0;
         pend_stop_reg <= 1'b0;
         pend_wrap_reg <= 1'b0;
         fall_seen_reg <= 1'b0;
      end
      else
      begin
         // [R4] twelve-bit rate setting
         // upper write data bits are dropped on purpose
         // [R5] rate setting locked while running
         if (dp_wr_reg && dp_addr_reg == `LFRTC_RATE_DIV && !run_reg)
            rate_reg <= i_hwdata[11:0];
         // route enable register and its set and clear aliases
         if (dp_wr_reg && dp_addr_reg == `LFRTC_ROUTE_EN)
            route_reg <= {i_hwdata[19:16], i_hwdata[1:0]};
         else if (dp_wr_reg && dp_addr_reg == `LFRTC_ROUTE_SET)
            route_reg <= route_reg | {i_hwdata[19:16], i_hwdata[1:0]};
         else if (dp_wr_reg && dp_addr_reg == `LFRTC_ROUTE_CLR)
            route_reg <= route_reg & ~{i_hwdata[19:16], i_hwdata[1:0]};
         // [R22] a falling edge arms the first advance
         if (lf_fall)
            armed_reg <= 1'b1;
         // [R14] start alone never advances, so it never matches
         // [R21] start runs on from the held value
         if (wr_start)
         begin
            run_reg <= 1'b1;
            armed_reg <= 1'b0;
            // [R6] divider restart on start
            div_reg <= rate_reg;
         end
         else if (advance)
            // [R3] reload on zero
            div_reg <= rate_reg;
         else if (run_reg && armed_reg && lf_rise && !task_now)
            div_reg <= div_reg - 12'h001;
         // [R1] count up
         if (advance)
            cnt_reg <= cnt_inc;
         // [R20] tasks wait for a falling edge
         if (wr_clear || wr_stop || wr_wrap)
         begin
            if (!any_pend)
               fall_seen_reg <= 1'b0;
            pend_clear_reg <= pend_clear_reg | wr_clear;
            pend_stop_reg <= pend_stop_reg | wr_stop;
            pend_wrap_reg <= pend_wrap_reg | wr_wrap;
         end
         else if (task_now)
         begin
            pend_clear_reg <= 1'b0;
            pend_stop_reg <= 1'b0;
            pend_wrap_reg <= 1'b0;
            fall_seen_reg <= 1'b0;
            // [R24] stop keeps the value
            if (pend_stop_reg)
               run_reg <= 1'b0;
            // [R8] load near wrap
            if (pend_wrap_reg)
               cnt_reg <= `LFRTC_NEAR_WRAP_VAL;
            // [R24] clear zeroes; [R13] no match on a load
            if (pend_clear_reg)
               cnt_reg <= 24'h000000;
            // [R6] divider restart on clear and near wrap
            if (pend_clear_reg || pend_wrap_reg)
               div_reg <= rate_reg;
         end
         else if (lf_fall && any_pend)
            fall_seen_reg <= 1'b1;
      end
   end

   // [R11] routed event pulses and clock request
   always @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_event <= 6'h00;
         o_clk_request <= 1'b0;
         o_running <= 1'b0;
      end
      else
      begin
         o_event <= ev_now & route_reg;
         o_clk_request <= |(ev_now & route_reg);
         o_running <= run_reg;
      end
   end

   // read multiplexer on the address-phase address
   always @*
   begin
      rd_mux = 32'h00000000;
      case (i_haddr[11:0])
         `LFRTC_EVT_TICK: rd_mux = {31'h00000000, evt_reg[0]};
         `LFRTC_EVT_WRAP: rd_mux = {31'h00000000, evt_reg[1]};
         `LFRTC_EVT_MATCH0: rd_mux = {31'h00000000, evt_reg[2]};
         `LFRTC_EVT_MATCH0 + 12'h004:
            rd_mux = {31'h00000000, evt_reg[3]};
         `LFRTC_EVT_MATCH0 + 12'h008:
            rd_mux = {31'h00000000, evt_reg[4]};
         `LFRTC_EVT_MATCH0 + 12'h00C:
            rd_mux = {31'h00000000, evt_reg[5]};
         `LFRTC_ROUTE_EN, `LFRTC_ROUTE_SET, `LFRTC_ROUTE_CLR:
            rd_mux = {12'h000, route_reg[5:2], 14'h0000, route_reg[1:0]};
         // [R19] fast-domain copy of the count
         `LFRTC_COUNT: rd_mux = {8'h00, cnt_reg};
         `LFRTC_RATE_DIV: rd_mux = {20'h00000, rate_reg};
         `LFRTC_MATCH_VAL0: rd_mux = {8'h00, match_reg[0]};
         `LFRTC_MATCH_VAL0 + 12'h004: rd_mux = {8'h00, match_reg[1]};
         `LFRTC_MATCH_VAL0 + 12'h008: rd_mux = {8'h00, match_reg[2]};
         `LFRTC_MATCH_VAL0 + 12'h00C: rd_mux = {8'h00, match_reg[3]};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // ahb-lite slave: address capture, read data, counter-read stall
   // read data is loaded at the address edge and held until the next
   // read, so a read straight after a write to the same place sees the
   // old value; the stall count runs down and raises ready on its last
   // step, giving exactly three low cycles
   always @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         dp_wr_reg <= 1'b0;
         dp_addr_reg <= 12'h000;
         stall_reg <= 2'h0;
         o_hrdata <= 32'h00000000;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end
      else
      begin
         o_hresp <= 1'b0;
         if (stall_reg != 2'h0)
         begin
            stall_reg <= stall_reg - 2'h1;
            if (stall_reg == 2'h1)
               o_hreadyout <= 1'b1;
            dp_wr_reg <= 1'b0;
         end
         else if (a_sel)
         begin
            dp_wr_reg <= i_hwrite;
            dp_addr_reg <= i_haddr[11:0];
            if (!i_hwrite)
               o_hrdata <= rd_mux;
            // [R23] three wait cycles on a counter read
            if (!i_hwrite && i_haddr[11:0] == `LFRTC_COUNT)
            begin
               stall_reg <= `LFRTC_READ_STALL;
               o_hreadyout <= 1'b0;
            end
         end
         else
            dp_wr_reg <= 1'b0;
      end
   end

endmodule

// >>> sim/lfrtc_asserts.sv
// port checker for the low-frequency real-time counter
`timescale 1ns/1ps
module lfrtc_asserts
(
   input wire i_mclk,
   input wire i_rst,
   input wire i_low_freq_clock,
   input wire i_hsel,
   input wire [31:0] i_haddr,
   input wire [1:0] i_htrans,
   input wire i_hwrite,
   input wire [2:0] i_hsize,
   input wire [31:0] i_hwdata,
   input wire i_hready,
   input wire [31:0] o_hrdata,
   input wire o_hreadyout,
   input wire o_hresp,
   input wire [5:0] o_event,
   input wire o_clk_request,
   input wire o_running
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   // accepted bus requests
   wire take = i_hsel && i_htrans[1] && i_hready && o_hreadyout;
   wire rd_take = take && !i_hwrite;
   wire cnt_rd = rd_take && (i_haddr[11:0] == 12'h504);
   wire ev_any = |o_event;
   sequence wr_task(a);
      take && i_hwrite && (i_haddr[11:0] == a) ##1 i_hwdata[0];
   endsequence
   // three wait cycles, then ready
   sequence s_stall;
      !o_hreadyout[*3] ##1 o_hreadyout;
   endsequence
   property p_stall;
      cnt_rd |=> s_stall;
   endproperty
   property p_no_stall;
      take && (i_hwrite || i_haddr[11:0] != 12'h504) |=> o_hreadyout;
   endproperty
   property p_hold;
      !$past(rd_take) |-> $stable(o_hrdata);
   endproperty
   property p_cause;
      o_clk_request |-> ev_any || $past(ev_any);
   endproperty
   property p_start;
      wr_task(12'h000) |-> ##[0:2] o_running;
   endproperty
   property p_stop;
      wr_task(12'h004) ##0 o_running |=> o_running[*2];
   endproperty
   AST_STALL: assert property (p_stall)
      else $error("count read stall has wrong length");
   AST_NO_STALL: assert property (p_no_stall)
      else $error("stall on a non-count access");
   AST_RESP: assert property (o_hresp == 1'b0)
      else $error("response not okay");
   AST_HOLD: assert property (p_hold)
      else $error("read data changed without a read");
   AST_PULSE: assert property (ev_any |=> o_event == 6'h00)
      else $error("event longer than one cycle");
   AST_REQ_FOLLOWS: assert property (ev_any |-> ##[0:1] o_clk_request)
      else $error("routed event made no clock request");
   AST_REQ_CAUSE: assert property (p_cause)
      else $error("clock request without routed event");
   AST_START: assert property (p_start)
      else $error("start did not set running");
   AST_STOP: assert property (p_stop)
      else $error("stop acted too early");
endmodule
bind lfrtc_top lfrtc_asserts lfrtc_asserts_inst (
   .i_mclk(i_mclk), .i_rst(i_rst),
   .i_low_freq_clock(i_low_freq_clock), .i_hsel(i_hsel), .i_haddr(i_haddr),
   .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
   .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata),
   .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_event(o_event),
   .o_clk_request(o_clk_request), .o_running(o_running));

// >>> sim/lfrtc_top_bench.sv
// self-checking bench for the low-frequency real-time counter
`timescale 1ns/1ps
module lfrtc_top_bench;
   reg i_mclk = 1'b0, i_rst = 1'b1, i_low_freq_clock = 1'b0, i_hsel = 1'b1;
   reg [31:0] i_haddr = 32'h0, i_hwdata = 32'h0;
   reg [1:0] i_htrans = 2'h0;
   reg i_hwrite = 1'b0;
   reg [2:0] i_hsize = 3'h2;
   wire [31:0] o_hrdata;
   wire o_hreadyout, o_hresp, o_clk_request, o_running;
   wire [5:0] o_event;
   wire i_hready = o_hreadyout;
   int failures = 0, samples_checked = 0, k;
   logic [31:0] q, c1;
   logic [11:0] rt;
   bit hit;
   lfrtc_top lfrtc_top_inst (.i_mclk(i_mclk), .i_rst(i_rst),
      .i_low_freq_clock(i_low_freq_clock), .i_hsel(i_hsel), .i_haddr(i_haddr),
      .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
      .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata),
      .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_event(o_event),
      .o_clk_request(o_clk_request), .o_running(o_running));
   // fast clock, and a faster-than-real slow clock of unrelated phase
   initial forever #5 i_mclk = ~i_mclk;
   initial
   begin
      #37;
      forever #200 i_low_freq_clock = ~i_low_freq_clock;
   end
   task stop_test;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // one ahb single transfer, then an idle cycle
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      i_haddr <= {20'h0, a};
      i_hwrite <= w;
      i_htrans <= 2'h2;
      do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
      i_htrans <= 2'h0;
      i_hwdata <= d;
      do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
      q = o_hrdata;
      @(posedge i_mclk);
   endtask
   task rd(input logic [11:0] a);
      xfer(1'b0, a, 32'h0);
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task slow(input int n);
      repeat (n * 40) @(posedge i_mclk);
   endtask
   // notes whether an event bit pulses within n cycles
   task watch(input int b, input int n);
      hit = 1'b0;
      repeat (n)
      begin
         @(posedge i_mclk);
         if (o_event[b] === 1'b1)
            hit = 1'b1;
      end
   endtask
   // route enable keeps only tick, wrap and the four match bits
   function automatic logic [31:0] route_of(input logic [31:0] w);
      route_of = w & 32'h000F0003;
   endfunction
   initial
   begin
      #600000;
      failures++;
      stop_test;
   end
   initial
   begin
      q = $urandom(32);
      repeat (4) @(posedge i_mclk);
      i_rst <= 1'b0;
      @(posedge i_mclk);
      rd(12'h340);
      chk(q, 32'h0);
      wr(12'h508, 32'hFFFFFFFF);
      rd(12'h508);
      chk(q, 32'hFFF);
      rt = 12'($urandom % 4);
      wr(12'h508, {20'h0, rt});
      rd(12'h508);
      chk(q, {20'h0, rt});
      // set alias keeps only routable bits
      wr(12'h344, 32'hFFFFFFFF);
      rd(12'h340);
      chk(q, route_of(32'hFFFFFFFF));
      wr(12'h000, 32'h1);
      @(posedge i_mclk);
      chk(o_running, 1'b1);
      wr(12'h508, {20'h0, ~rt});
      rd(12'h508);
      chk(q, {20'h0, rt});
      rd(12'h504);
      c1 = q;
      slow(10 * (rt + 1));
      rd(12'h504);
      chk((q - c1 >= 9) && (q - c1 <= 11), 1'b1);
      // every match slot at count plus two
      for (k = 0; k < 4; k++)
      begin
         rd(12'h504);
         wr(12'(12'h540 + 4 * k), q + 2);
         watch(2 + k, 1000);
         chk(hit, 1'b1);
         rd(12'(12'h140 + 4 * k));
         chk(q, 32'h1);
      end
      wr(12'h00C, 32'h1);
      slow(3);
      rd(12'h504);
      chk(q[23:4], 20'hFFFFF);
      watch(1, 640 * (rt + 1) + 400);
      chk(hit, 1'b1);
      wr(12'h348, 32'hFFFFFFFF);
      rd(12'h340);
      chk(q, 32'h0);
      wr(12'h100, 32'h0);
      watch(0, 200 * (rt + 1));
      chk(hit, 1'b0);
      rd(12'h100);
      chk(q, 32'h1);
      wr(12'h004, 32'h1);
      slow(3);
      chk(o_running, 1'b0);
      rd(12'h504);
      c1 = q;
      slow(2 * (rt + 1) + 2);
      rd(12'h504);
      chk(q, c1);
      wr(12'h344, 32'h00010000);
      wr(12'h540, 32'h0);
      wr(12'h008, 32'h1);
      watch(2, 160);
      chk(hit, 1'b0);
      rd(12'h504);
      chk(q, 32'h0);
      wr(12'h000, 32'h1);
      watch(2, 60);
      chk(hit, 1'b0);
      wr(12'h7F0, $urandom);
      rd(12'h7F0);
      chk(q, 32'h0);
      stop_test;
   end
endmodule
